// ===== rtl/bss_pkg.sv
// Package for the bridge secondary status and capability link block.
// Assumes a 32-bit word-wide configuration access port.
package bss_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] BSS_CAP_STAT_OFF = 8'h80;
  localparam logic [7:0] BSS_IRQ_STAT_OFF = 8'hC0;
  localparam logic [7:0] BSS_IRQ_MASK_OFF = 8'hC4;
  localparam logic [7:0] BSS_NEXT_CAP_VAL = 8'h90;

  // ==========================================================
  // Field positions
  localparam int BSS_NEXT_LSB = 8;
  localparam int BSS_B64_BIT = 16;
  localparam int BSS_M133_BIT = 17;
  localparam int BSS_DISC_BIT = 18;
  localparam int BSS_UNEXP_BIT = 19;
  localparam int BSS_OVR_BIT = 20;
  localparam int BSS_DLY_BIT = 21;
  localparam int BSS_FREQ_LSB = 22;

  // ==========================================================
  // Reset values of the frequency code, events and mask
  localparam logic [2:0] BSS_FREQ_RST = 3'h0;
  localparam logic [3:0] BSS_EVT_RST = 4'h0;
  localparam logic [3:0] BSS_MASK_RST = 4'h0;

  // Event vector: discarded, unexpected, overrun, delayed
  typedef struct packed {
    logic dly;
    logic ovr;
    logic unexp;
    logic disc;
  } bss_evt_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bss_req_s;

endpackage : bss_pkg

// ===== rtl/bss_status.sv
// Secondary status half-word, next capability link, event interrupt.
// Assumes strap and events synchronous to clk_i; strap sampled at reset.
`timescale 1ns/100ps
`default_nettype none

module bss_status
  import bss_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reverse_mode_i,
  input wire logic [2:0] sec_clk_code_i,
  input wire logic evt_discard_i,
  input wire logic evt_unexpected_i,
  input wire logic evt_overrun_i,
  input wire logic evt_delayed_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic rev;
    logic m133;
    logic [2:0] freq;
    bss_evt_s sts;
    bss_evt_s irq_sts;
    bss_evt_s mask;
    logic [31:0] rdata;
    logic irq;
  } bss_state_s;

  bss_state_s st_q;
  bss_state_s st_d;
  bss_evt_s ev;
  bss_req_s req;

  // Compose the status word from state
  function automatic logic [31:0] stat_word(input bss_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BSS_NEXT_LSB +: 8] = BSS_NEXT_CAP_VAL;
    w[BSS_B64_BIT] = 1'b0;
    w[BSS_M133_BIT] = s.m133;
    w[BSS_DISC_BIT] = s.sts.disc;
    w[BSS_UNEXP_BIT] = s.sts.unexp;
    w[BSS_OVR_BIT] = s.sts.ovr;
    w[BSS_DLY_BIT] = s.sts.dly;
    w[BSS_FREQ_LSB +: 3] = s.rev ? 3'h0 : s.freq;
    return w;
  endfunction : stat_word

  // Gate events by mode
  always_comb begin
    req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    ev.disc = evt_discard_i & ~st_q.rev;
    ev.unexp = evt_unexpected_i & st_q.rev;
    ev.ovr = evt_overrun_i;
    ev.dly = evt_delayed_i;
  end

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;
    st_d.freq = st_q.rev ? 3'h0 : sec_clk_code_i;
    // Write one to clear, event set wins
    if (req.wr && req.addr == BSS_CAP_STAT_OFF) begin
      st_d.sts.disc = st_q.sts.disc & ~req.wdata[BSS_DISC_BIT];
      st_d.sts.unexp = st_q.sts.unexp & ~req.wdata[BSS_UNEXP_BIT];
      st_d.sts.ovr = st_q.sts.ovr & ~req.wdata[BSS_OVR_BIT];
      st_d.sts.dly = st_q.sts.dly & ~req.wdata[BSS_DLY_BIT];
    end
    if (req.wr && req.addr == BSS_IRQ_MASK_OFF) begin
      st_d.mask = req.wdata[3:0];
    end
    st_d.sts = st_d.sts | ev;
    if (st_q.rev) begin
      st_d.sts.disc = 1'b0;
    end else begin
      st_d.sts.unexp = 1'b0;
    end
    // Interrupt status, cleared by its read
    if (req.rd && req.addr == BSS_IRQ_STAT_OFF) begin
      st_d.irq_sts = ev;
    end else begin
      st_d.irq_sts = st_q.irq_sts | ev;
    end
    // Read data
    if (req.rd) begin
      case (req.addr)
        BSS_CAP_STAT_OFF: st_d.rdata = stat_word(st_q);
        BSS_IRQ_STAT_OFF: st_d.rdata = {28'h000_0000, st_q.irq_sts};
        BSS_IRQ_MASK_OFF: st_d.rdata = {28'h000_0000, st_q.mask};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.irq = |(st_d.irq_sts & st_d.mask);
  end

  // Registers; strap caught on the reset cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q <= '0;
      st_q.rev <= reverse_mode_i;
      st_q.m133 <= ~reverse_mode_i;
      st_q.freq <= BSS_FREQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign irq_o = st_q.irq;

  // ==========================================================
  // Assertions
  link_const_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == BSS_CAP_STAT_OFF |=> rdata_o[15:8] == BSS_NEXT_CAP_VAL &&
    rdata_o[16] == 1'b0 && rdata_o[31:25] == 7'h00)
    else $error("link byte or fixed bits wrong");
  no_wide_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i |=> !rdata_o[16])
    else $error("64-bit bit set");
  m133_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q.m133 == !st_q.rev)
    else $error("133 bit mismatches mode");
  disc_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    evt_discard_i && !st_q.rev |=> st_q.sts.disc)
    else $error("discard not recorded");
  disc_rev_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_q.rev |=> !st_q.sts.disc)
    else $error("discard set in reverse");
  unexp_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    evt_unexpected_i && st_q.rev |=> st_q.sts.unexp)
    else $error("unexpected not recorded");
  unexp_fwd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !st_q.rev |=> !st_q.sts.unexp)
    else $error("unexpected set in forward");
  ovr_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    evt_overrun_i |=> st_q.sts.ovr [*1])
    else $error("overrun not recorded");
  dly_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    evt_delayed_i |=> st_q.sts.dly)
    else $error("delay not recorded");
  freq_rev_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == BSS_CAP_STAT_OFF && st_q.rev |=>
    rdata_o[24:22] == 3'h0)
    else $error("clock code nonzero in reverse");
  freq_fwd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !st_q.rev ##1 !st_q.rev |-> st_q.freq == $past(sec_clk_code_i))
    else $error("clock code not tracked");
  w1c_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_i && addr_i == BSS_CAP_STAT_OFF && wdata_i[BSS_OVR_BIT] &&
    !evt_overrun_i
    |=> !st_q.sts.ovr)
    else $error("write one did not clear");
  w0_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_i && addr_i == BSS_CAP_STAT_OFF && !wdata_i[21] && st_q.sts.dly
    |=> st_q.sts.dly)
    else $error("write zero cleared bit");

  disc_cov_c: cover property (@(posedge clk_i) st_q.sts.disc);
  unexp_cov_c: cover property (@(posedge clk_i) st_q.sts.unexp);
  irq_cov_c: cover property (@(posedge clk_i) irq_o ##1 !irq_o);
  clr_cov_c: cover property (@(posedge clk_i)
    st_q.sts.ovr ##1 !st_q.sts.ovr);

endmodule : bss_status

`default_nettype wire

// ===== verification/bss_agent.sv
// Model of the secondary-bus agents that raise split events.
// Assumes one-cycle event pulses launched after a clk_i edge.
`timescale 1ns/100ps
`default_nettype none
module bss_agent
  import bss_pkg::*;
(
  input wire logic clk_i,
  output var bss_evt_s evt_o
);
  // ======
  // Event pulses, one cycle per call
  initial evt_o = '0;
  task automatic emit(input bss_evt_s e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask : emit
endmodule : bss_agent
`default_nettype wire

// ===== verification/tb_top.sv
// Bench for the secondary status word, link byte and event interrupt.
// Assumes the agent model drives all four event inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bss_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reverse_mode_i = 1'b0;
  logic [2:0] sec_clk_code_i = 3'h0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  bss_evt_s evt;
  logic [31:0] got;
  int err_total = 0;
  int checked = 0;
  logic [31:0] row_exp [3] = '{32'h0002_9000, 32'h0042_9000, 32'h0082_9000};
  // ======
  // Clock and instances
  initial forever #12.5 clk_i = ~clk_i;
  bss_agent bss_agent_i (.clk_i(clk_i), .evt_o(evt));
  bss_status bss_status_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .reverse_mode_i(reverse_mode_i), .sec_clk_code_i(sec_clk_code_i),
    .evt_discard_i(evt.disc), .evt_unexpected_i(evt.unexp),
    .evt_overrun_i(evt.ovr), .evt_delayed_i(evt.dly), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));
  // ======
  // Compare, bus cycles, reset, verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask : rd
  task automatic boot(input logic rev);
    resetn_i <= 1'b0;
    reverse_mode_i <= rev;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask : boot
  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ======
  // Main sequence: rows first, then events and modes
  initial begin
    boot(1'b0);
    for (int i = 0; i < 3; i++) begin
      sec_clk_code_i <= i[2:0];
      repeat (2) @(posedge clk_i);
      rd(BSS_CAP_STAT_OFF);
      chk("word", row_exp[i], got);
    end
    sec_clk_code_i <= 3'h0;
    wr(BSS_IRQ_MASK_OFF, 32'h0000_0004);
    bss_agent_i.emit(4'hF);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", 32'h0000_0001, {31'h0, irq_o});
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0036_9000, got);
    @(posedge clk_i);
    #1 chk("idle", 32'h0000_0000, rdata_o);
    rd(BSS_IRQ_STAT_OFF);
    chk("irqst", 32'h0000_000D, got);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq_o});
    wr(BSS_CAP_STAT_OFF, 32'h0000_0000);
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0036_9000, got);
    wr(BSS_CAP_STAT_OFF, 32'hFFFF_FFFF);
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0002_9000, got);
    rd(8'h10);
    chk("unmapped", 32'h0000_0000, got);
    // Clear and overrun event on the same edge: the set wins
    fork
      wr(BSS_CAP_STAT_OFF, 32'hFFFF_FFFF);
      bss_agent_i.emit(4'h4);
    join
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0012_9000, got);
    wr(BSS_CAP_STAT_OFF, 32'hFFFF_FFFF);
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0002_9000, got);
    // Reverse mode after a second reset, launched on a clock edge
    @(posedge clk_i);
    sec_clk_code_i <= 3'h2;
    boot(1'b1);
    bss_agent_i.emit(4'hF);
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0038_9000, got);
    chk("irq", 32'h0000_0000, {31'h0, irq_o});
    wr(BSS_CAP_STAT_OFF, 32'hFFFF_FFFF);
    rd(BSS_CAP_STAT_OFF);
    chk("word", 32'h0000_9000, got);
    final_report();
  end
  // Watchdog against a hung run
  initial begin
    #50000;
    err_total++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
